// *** src/twelve_bit_interval_timer.sv ***
// Twelve-bit interval timer with an AXI4-Lite register slave.
// Assumes lowspeed_osc_clock is a slow asynchronous clock, well below
// half of aclk, sampled here through the two-stage level_sync synchroniser.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps

// Operation
// - Interval request is produced regardless of processor stop or halt.
// - Twelve-bit up-counter counts count-clock cycles once run_enable is one.
// - On compare match counter clears, keeps counting, request raised.
// - Period is compare_value plus one count clocks; zero compare forbidden.
// - Writing zero to run_enable stops counting and clears the counter.
// - Clock gate bit 7 gates the timer; off holds it in reset.
// - Gate off: control writes ignored, reads default; speed mode excepted.
// - count_clk_select one supplies the oscillator clock, zero stops it.
// - run_enable readback reflects a written one one count clock later.
// - Reset: control 0FFFH, peripheral enable and speed mode 00H.
module twelve_bit_interval_timer
  import itimer_pkg::*;
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         lowspeed_osc_clock,
  input  wire logic [itimer_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                   awprot,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [itimer_pkg::DATA_W-1:0] wdata,
  input  wire logic [itimer_pkg::STRB_W-1:0] wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  input  wire logic [itimer_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                   arprot,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [itimer_pkg::DATA_W-1:0]     rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  output logic                              interval_irq,
  output logic                              irq
);
  import itimer_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]        pce_r;
  logic [7:0]        smc_r;
  logic [CMP_W-1:0]  cmp_r;
  logic              run_wr_r;
  logic              run_act_r;
  logic [CMP_W-1:0]  cnt_r;
  logic              pulse_r;
  logic              stat_r;
  logic              ien_r;
  logic              aw_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              w_held_r;
  logic [DATA_W-1:0] w_data_r;
  logic [STRB_W-1:0] w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic [1:0]        rd_resp_nxt;
  logic [IDX_W-1:0]  wr_idx;
  logic [IDX_W-1:0]  rd_idx;
  logic              osc_rise;
  logic              gate;
  logic              tick;
  logic              match;
  logic              do_write;
  logic              wr_mapped;
  logic              itc_wr;
  logic              stat_clr;

  // ---------------------------------------------------------------
  // Count clock
  // ---------------------------------------------------------------
  level_sync osc_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (lowspeed_osc_clock),
    .level   (),
    .rise    (osc_rise)
  );

  assign gate  = pce_r[GATE_BIT];
  assign tick  = osc_rise & smc_r[CLK_SEL_BIT] & gate;
  // Zero compare would match every tick; software must avoid it
  assign match = run_act_r & tick & (cnt_r == cmp_r);

  // ---------------------------------------------------------------
  // Bus write path
  // ---------------------------------------------------------------
  assign awready  = ~aw_held_r & ~bvalid_r;
  assign wready   = ~w_held_r & ~bvalid_r;
  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_idx   = aw_addr_r[ADDR_W-1:2];
  assign wr_mapped = (wr_idx == PCE_IDX) | (wr_idx == SMC_IDX) |
                     (wr_idx == ITC_IDX) | (wr_idx == STAT_IDX) |
                     (wr_idx == IEN_IDX) | (wr_idx == CNT_IDX);
  // Control writes land only while the gate is on
  assign itc_wr   = do_write & (wr_idx == ITC_IDX) & gate;
  assign stat_clr = do_write & (wr_idx == STAT_IDX) &
                    w_strb_r[LANE_LO] & w_data_r[IRQ_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (awvalid && awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (wvalid && wready) begin
      w_held_r <= 1'b1;
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Peripheral enable and speed mode stay writable with the gate off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pce_r <= PCE_RST;
      smc_r <= SMC_RST;
    end else if (do_write && w_strb_r[LANE_LO]) begin
      if (wr_idx == PCE_IDX) begin
        pce_r <= w_data_r[7:0];
      end
      if (wr_idx == SMC_IDX) begin
        smc_r <= w_data_r[7:0] & SMC_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !gate) begin
      cmp_r    <= CMP_ALL;
      run_wr_r <= 1'b0;
    end else if (itc_wr) begin
      if (w_strb_r[LANE_LO]) begin
        cmp_r[7:0] <= w_data_r[7:0];
      end
      if (w_strb_r[LANE_HI]) begin
        cmp_r[CMP_W-1:8] <= w_data_r[CMP_W-1:8];
        run_wr_r         <= w_data_r[RUN_BIT];
      end
    end
  end

  // Written one is taken on the next count tick, so readback lags
  always_ff @(posedge aclk) begin
    if (!aresetn || !gate) begin
      run_act_r <= 1'b0;
    end else if (itc_wr && w_strb_r[LANE_HI] && !w_data_r[RUN_BIT]) begin
      run_act_r <= 1'b0;
    end else if (tick) begin
      run_act_r <= run_wr_r;
    end
  end

  // ---------------------------------------------------------------
  // Counter and interval request
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !gate || !run_act_r) begin
      cnt_r <= CNT_ZERO;
    end else if (match) begin
      cnt_r <= CNT_ZERO;
    end else if (tick) begin
      cnt_r <= cnt_r + CNT_ONE;
    end
  end

  // No core power state enters here, so stop and halt cannot block it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= match;
    end
  end

  assign interval_irq = pulse_r;

  // Set beats a simultaneous write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~stat_clr) | pulse_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_r <= 1'b0;
    end else if (do_write && wr_idx == IEN_IDX && w_strb_r[LANE_LO]) begin
      ien_r <= w_data_r[IRQ_BIT];
    end
  end

  assign irq = stat_r & ien_r;

  // ---------------------------------------------------------------
  // Bus read path
  // ---------------------------------------------------------------
  assign arready = ~rvalid_r;
  assign rd_idx  = araddr[ADDR_W-1:2];

  always_comb begin
    rd_data_nxt = '0;
    rd_resp_nxt = RESP_OKAY;
    case (rd_idx)
      PCE_IDX:  rd_data_nxt[7:0] = pce_r;
      SMC_IDX:  rd_data_nxt[7:0] = smc_r;
      ITC_IDX: begin
        rd_data_nxt[15:0] = ITC_RST;
        if (gate) begin
          rd_data_nxt[CMP_W-1:0] = cmp_r;
          rd_data_nxt[RUN_BIT]   = run_act_r;
        end
      end
      STAT_IDX: rd_data_nxt[IRQ_BIT] = stat_r;
      IEN_IDX:  rd_data_nxt[IRQ_BIT] = ien_r;
      CNT_IDX:  rd_data_nxt[CMP_W-1:0] = cnt_r;
      default:  rd_resp_nxt = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_resp_nxt;
      rdata_r  <= rd_data_nxt;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rresp  = rresp_r;
  assign rdata  = rdata_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_gate_off_reset: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !gate |=> (cnt_r == CNT_ZERO) && !run_act_r && (cmp_r == CMP_ALL))
    else $error("timer not held in reset with gate off");

  a_match_clears: assert property (@(posedge aclk)
    disable iff (!aresetn)
    match && gate |=> (cnt_r == CNT_ZERO) && interval_irq)
    else $error("match did not clear counter and raise request");

  a_pulse_single: assert property (@(posedge aclk)
    disable iff (!aresetn)
    interval_irq |=> !interval_irq ##1 !interval_irq)
    else $error("interval request longer than one cycle");

  a_count_step: assert property (@(posedge aclk)
    disable iff (!aresetn)
    gate && run_act_r && tick && !match
    |=> cnt_r == $past(cnt_r) + CNT_ONE)
    else $error("counter did not advance on tick");

  a_stop_clears: assert property (@(posedge aclk)
    disable iff (!aresetn)
    itc_wr && w_strb_r[LANE_HI] && !w_data_r[RUN_BIT]
    |=> !run_act_r ##1 (cnt_r == CNT_ZERO && !interval_irq))
    else $error("stop write did not clear counter");

  a_run_lags: assert property (@(posedge aclk)
    disable iff (!aresetn)
    $rose(run_act_r) |-> $past(tick) && $past(run_wr_r))
    else $error("run readback changed without a count tick");

  // Reachable once software drops the count clock while stopped
  a_clock_stop: assert property (@(posedge aclk)
    disable iff (!aresetn)
    gate && !smc_r[CLK_SEL_BIT]
    |=> cnt_r == $past(cnt_r) && !$rose(run_act_r))
    else $error("timer moved with count clock stopped");

  a_gated_read: assert property (@(posedge aclk)
    disable iff (!aresetn)
    arvalid && arready && rd_idx == ITC_IDX && !gate
    |=> rdata == {16'h0000, ITC_RST})
    else $error("gated control read not default");

  a_reset_values: assert property (@(posedge aclk)
    !aresetn |=> cmp_r == CMP_ALL && !run_act_r && pce_r == PCE_RST &&
                 smc_r == SMC_RST)
    else $error("reset values wrong");

  a_irq_sticky: assert property (@(posedge aclk)
    disable iff (!aresetn)
    interval_irq |=> stat_r ##0 (irq == ien_r))
    else $error("request did not set status");

  c_match: cover property (@(posedge aclk) disable iff (!aresetn)
    interval_irq);
  c_restart: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(run_act_r));
  c_gated_write: cover property (@(posedge aclk) disable iff (!aresetn)
    do_write && wr_idx == ITC_IDX && !gate);
  c_clear_race: cover property (@(posedge aclk) disable iff (!aresetn)
    stat_clr && pulse_r);

endmodule : twelve_bit_interval_timer

// *** src/itimer_pkg.sv ***
// Constants shared by the interval timer and its register slave.
// Assumes a 32-bit AXI4-Lite bus; byte address is four times the index.
package itimer_pkg;

  // ---------------------------------------------------------------
  // Bus geometry and answers
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 22;
  localparam int          DATA_W      = 32;
  localparam int          STRB_W      = 4;
  localparam int          IDX_W       = ADDR_W - 2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          LANE_LO     = 0;
  localparam int          LANE_HI     = 1;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] PCE_IDX  = 20'hF00F0;
  localparam logic [IDX_W-1:0] SMC_IDX  = 20'hF00F3;
  localparam logic [IDX_W-1:0] ITC_IDX  = 20'hFFF90;
  localparam logic [IDX_W-1:0] STAT_IDX = 20'hF0100;
  localparam logic [IDX_W-1:0] IEN_IDX  = 20'hF0101;
  localparam logic [IDX_W-1:0] CNT_IDX  = 20'hF0102;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int           CMP_W      = 12;
  localparam int           GATE_BIT   = 7;
  localparam int           CLK_SEL_BIT = 4;
  localparam int           RUN_BIT    = 15;
  localparam int           IRQ_BIT    = 0;
  localparam logic [7:0]   PCE_RST    = 8'h00;
  localparam logic [7:0]   SMC_RST    = 8'h00;
  localparam logic [7:0]   SMC_MASK   = 8'h10;
  localparam logic [15:0]  ITC_RST    = 16'h0FFF;
  localparam logic [CMP_W-1:0] CMP_ALL  = 12'hFFF;
  localparam logic [CMP_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CMP_W-1:0] CNT_ONE  = 12'h001;

endpackage : itimer_pkg

// *** src/level_sync.sv ***
// Two-stage synchroniser with a registered rising-edge pulse.
// Assumes din is asynchronous to aclk.
`timescale 1ns/100ps
module level_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      level,
  output logic      rise
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic rise_r;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      prev_r <= sync_r;
      rise_r <= sync_r & ~prev_r;
    end
  end

  assign level = sync_r;
  assign rise  = rise_r;

endmodule : level_sync

// *** test/twelve_bit_interval_timer_tb.sv ***
// Self-checking bench for the twelve-bit interval timer.
// Assumes itimer_pkg and the timer top are compiled before this file.
`timescale 1ns/100ps
module twelve_bit_interval_timer_tb;
  import itimer_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic              aclk, aresetn, osc;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd;
  logic [STRB_W-1:0] wstrb;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, last_resp;
  logic              interval_irq, irq, prev_pulse;
  logic [CMP_W-1:0]  cmps [2] = '{12'h001, 12'h005};
  int                fail_count, checks, pulses, p, k;

  twelve_bit_interval_timer DUT (
    .aclk(aclk), .aresetn(aresetn), .lowspeed_osc_clock(osc),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .interval_irq(interval_irq), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic axi_wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    int n;
    bit aw_ok;
    bit w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr  <= {idx, 2'h0};
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok) && n < 40);
    while (bvalid !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    // Ready stays high between transfers, so no double drive
    last_resp = bresp;
    if (n >= 40)
      chk("write_done", 32'h1, 32'h0);
  endtask : axi_wr

  task automatic axi_rd(input logic [IDX_W-1:0] idx, output logic [31:0] d);
    int n;
    n = 0;
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 40);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    d = rdata;
    last_resp = rresp;
    if (n >= 40)
      chk("read_done", 32'h1, 32'h0);
  endtask : axi_rd

  task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] exp,
                        input string name);
    logic [31:0] d;
    axi_rd(idx, d);
    chk(name, exp, d);
  endtask : rd_chk

  // n count-clock cycles, held still afterwards
  task automatic tick(input int n);
    repeat (n) begin
      osc <= 1'b1;
      repeat (5) @(posedge aclk);
      osc <= 1'b0;
      repeat (5) @(posedge aclk);
    end
  endtask : tick

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // Pulse monitor
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    if (interval_irq === 1'b1)
      pulses <= pulses + 1;
    if (interval_irq === 1'b1 && prev_pulse === 1'b1)
      chk("pulse_width", 32'h0, 32'h1);
    prev_pulse <= interval_irq;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    $display("mismatch watchdog expected done seen hung");
    end_of_test();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    aresetn <= 1'b0;
    osc <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    awaddr <= '0;
    araddr <= '0;
    wdata <= '0;
    wstrb <= 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(PCE_IDX, 32'h0000_0000, "pce_reset");
    rd_chk(SMC_IDX, 32'h0000_0000, "smc_reset");
    rd_chk(ITC_IDX, 32'h0000_0FFF, "itc_reset");
    axi_rd(20'h00010, rd);
    chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, last_resp});
    axi_wr(20'h00010, 32'h0000_0000);
    chk("unmapped_wr_resp", {30'h0, RESP_SLVERR}, {30'h0, last_resp});
    $display("test reset_values done");

    axi_wr(ITC_IDX, 32'h0000_8005);
    chk("gated_wr_resp", {30'h0, RESP_OKAY}, {30'h0, last_resp});
    rd_chk(ITC_IDX, 32'h0000_0FFF, "itc_gate_off");
    axi_wr(SMC_IDX, 32'h0000_0010);
    rd_chk(SMC_IDX, 32'h0000_0010, "smc_gate_off");
    axi_wr(PCE_IDX, 32'h0000_0080);
    rd_chk(PCE_IDX, 32'h0000_0080, "pce_gate_on");
    $display("test gate_off done");

    foreach (cmps[i]) begin
      axi_wr(ITC_IDX, {16'h0000, 4'h8, cmps[i]});
      rd_chk(ITC_IDX, {20'h0, cmps[i]}, "run_before_tick");
      tick(1);
      rd_chk(ITC_IDX, {16'h0, 4'h8, cmps[i]}, "run_after_tick");
      p = pulses;
      for (k = 0; k < 2 * cmps[i] + 4 && pulses == p; k++)
        tick(1);
      chk("first_match", p + 1, pulses);
      p = pulses;
      tick(cmps[i]);
      chk("no_early_match", p, pulses);
      tick(1);
      chk("period_match", p + 1, pulses);
      rd_chk(CNT_IDX, 32'h0, "count_cleared");
      tick(1);
      rd_chk(CNT_IDX, 32'h1, "count_running");
      rd_chk(STAT_IDX, 32'h1, "status_set");
      chk("irq_masked", 32'h0, {31'h0, irq});
      axi_wr(IEN_IDX, 32'h1);
      chk("irq_unmasked", 32'h1, {31'h0, irq});
      axi_wr(IEN_IDX, 32'h0);
      axi_wr(ITC_IDX, {20'h0, cmps[i]});
      rd_chk(CNT_IDX, 32'h0, "count_stop");
      p = pulses;
      tick(cmps[i] + 2);
      chk("stopped_quiet", p, pulses);
      axi_wr(STAT_IDX, 32'h1);
      rd_chk(STAT_IDX, 32'h0, "status_clear");
      $display("test interval %0d done", cmps[i]);
    end

    axi_wr(ITC_IDX, 32'h0000_8003);
    tick(2);
    axi_wr(PCE_IDX, 32'h0000_0000);
    rd_chk(ITC_IDX, 32'h0000_0FFF, "itc_gate_cleared");
    axi_wr(PCE_IDX, 32'h0000_0080);
    rd_chk(ITC_IDX, 32'h0000_0FFF, "itc_regate");
    rd_chk(CNT_IDX, 32'h0, "count_regate");
    $display("test gate_clear done");

    // Count clock withdrawn while stopped, then restored and polled
    axi_wr(SMC_IDX, 32'h0000_0000);
    axi_wr(ITC_IDX, 32'h0000_8002);
    tick(2);
    rd_chk(ITC_IDX, 32'h0000_0002, "run_clock_stopped");
    rd_chk(CNT_IDX, 32'h0, "count_clock_stopped");
    axi_wr(SMC_IDX, 32'h0000_0010);
    k = 0;
    do begin
      tick(1);
      axi_rd(ITC_IDX, rd);
      k++;
    end while (!rd[RUN_BIT] && k < 4);
    chk("run_polled", 32'h0000_8002, rd);
    $display("test clock_stop done");
    end_of_test();
  end

endmodule : twelve_bit_interval_timer_tb
